// *** pirm_pkg.sv ***
// Shared constants, types and helpers for the motion module controller.
// Assumes a single 100 MHz system clock; times are turned into cycles here.
package pirm_pkg;

   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned BAUD = 9600;
   localparam int unsigned BAUD_CYC = CLK_HZ / BAUD;
   localparam int unsigned STAB_S = 20;
   localparam int unsigned STAB_CYC = STAB_S * CLK_HZ;
   localparam int unsigned TMO_MS = 2500;
   localparam int unsigned TMO_CYC = TMO_MS * (CLK_HZ / 1000);
   localparam int unsigned SEC_CYC = CLK_HZ;
   localparam int unsigned SAMPLE_MS = 100;
   localparam int unsigned SAMPLE_CYC = SAMPLE_MS * (CLK_HZ / 1000);
   localparam logic [1:0] SYNC_CYC = 2'd2;

   localparam logic [7:0] CH_ACK = 8'h06;
   localparam logic [7:0] CH_NACK = 8'h15;
   localparam logic [7:0] CH_YES = 8'h59;
   localparam logic [7:0] CH_NO = 8'h4e;
   localparam logic [7:0] CH_UNSTABLE = 8'h55;

   localparam logic [7:0] CMD_STATUS_RD = 8'h61;
   localparam logic [7:0] CMD_ACT_RD = 8'h64;
   localparam logic [7:0] CMD_ACT_WR = 8'h44;
   localparam logic [7:0] CMD_UNSOL_RD = 8'h6d;
   localparam logic [7:0] CMD_UNSOL_WR = 8'h4d;
   localparam logic [7:0] CMD_SENS_RD = 8'h73;
   localparam logic [7:0] CMD_SENS_WR = 8'h53;
   localparam logic [7:0] CMD_RESET = 8'h58;
   localparam logic [31:0] CONF_SEQ = 32'h31323334;

   localparam logic [7:0] ACT_RST = 8'h02;
   localparam logic [7:0] SENS_RST = 8'h10;

   typedef enum {PH_HOLD, PH_STAB, PH_RUN} pirm_phase_e;
   typedef enum {CI_IDLE, CI_WDATA, CI_CONF} pirm_cmd_e;

   typedef struct packed {
      logic [3:0] hold;
      logic [7:0] sens;
      logic light;
      logic sleep_n;
   } pirm_pins_s;

   // Hold-time setting step to seconds, 2 s up to 15 min
   function automatic logic [9:0] hold_secs(input logic [3:0] idx);
      case (idx)
         4'h0: hold_secs = 10'h002;
         4'h1: hold_secs = 10'h005;
         4'h2: hold_secs = 10'h00a;
         4'h3: hold_secs = 10'h01e;
         4'h4: hold_secs = 10'h03c;
         4'h5: hold_secs = 10'h078;
         4'h6: hold_secs = 10'h0b4;
         4'h7: hold_secs = 10'h12c;
         4'h8: hold_secs = 10'h258;
         default: hold_secs = 10'h384;
      endcase
   endfunction

   function automatic logic [7:0] conf_byte(input logic [1:0] idx);
      conf_byte = CONF_SEQ[8*(3-idx) +: 8];
   endfunction

endpackage

// *** pirm_uart.sv ***
// Byte serial port, 8 data bits, no parity, one stop bit.
// Assumes rxd is an asynchronous pin; the bit period is DIV system clocks.
`timescale 1ns/10ps
module pirm_uart
   import pirm_pkg::*;
#(
   parameter int unsigned DIV = BAUD_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic rxd,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   output logic txd
);

   if (DIV < 4 || DIV > 65535) begin : g_bad_div
      $error("pirm_uart: DIV out of range");
   end

   logic rx_m_q, rx_s_q, rx_act_q, tx_act_q;
   logic [15:0] rx_cnt_q, tx_cnt_q;
   logic [3:0] rx_bit_q, tx_bit_q;
   logic [7:0] rx_sh_q, tx_sh_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_m_q <= 1'b1;
         rx_s_q <= 1'b1;
      end else begin
         rx_m_q <= rxd;
         rx_s_q <= rx_m_q;
      end
   end

   // Start edge, then sample mid-bit; a start bit that is high at mid-bit is noise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_act_q <= 1'b0;
         rx_cnt_q <= 16'h0000;
         rx_bit_q <= 4'h0;
         rx_sh_q <= 8'h00;
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_act_q) begin
            if (!rx_s_q) begin
               rx_act_q <= 1'b1;
               rx_cnt_q <= 16'(DIV / 2);
               rx_bit_q <= 4'h0;
            end
         end else if (rx_cnt_q != 16'h0000) begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
         end else begin
            rx_cnt_q <= 16'(DIV - 1);
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && rx_s_q) begin
               rx_act_q <= 1'b0;
            end else if (rx_bit_q == 4'h9) begin
               rx_act_q <= 1'b0;
               rx_valid <= rx_s_q;
               rx_data <= rx_sh_q;
            end else if (rx_bit_q != 4'h0) begin
               rx_sh_q <= {rx_s_q, rx_sh_q[7:1]};
            end
         end
      end
   end

   assign tx_ready = !tx_act_q;

   // Start bit, eight data bits LSB first, stop bit
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_act_q <= 1'b0;
         tx_cnt_q <= 16'h0000;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 8'h00;
         txd <= 1'b1;
      end else if (!tx_act_q) begin
         if (tx_valid) begin
            tx_act_q <= 1'b1;
            tx_cnt_q <= 16'(DIV - 1);
            tx_bit_q <= 4'h0;
            tx_sh_q <= tx_data;
            txd <= 1'b0;
         end
      end else if (tx_cnt_q != 16'h0000) begin
         tx_cnt_q <= tx_cnt_q - 16'h0001;
      end else begin
         tx_cnt_q <= 16'(DIV - 1);
         tx_bit_q <= tx_bit_q + 4'h1;
         if (tx_bit_q == 4'h9) begin
            tx_act_q <= 1'b0;
         end else if (tx_bit_q == 4'h8) begin
            txd <= 1'b1;
         end else begin
            txd <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
         end
      end
   end

endmodule

// *** pirm_ctrl.sv ***
// Motion module controller: power-on sequencing, mode strap, motion output,
// sleep and the serial command interpreter.
// Assumes detector events and setting codes come from logic on this clock.
`timescale 1ns/10ps
module pirm_ctrl
   import pirm_pkg::*;
#(
   parameter int unsigned STAB_CYCLES = STAB_CYC,
   parameter int unsigned TMO_CYCLES = TMO_CYC,
   parameter int unsigned SEC_CYCLES = SEC_CYC,
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
   parameter int unsigned BAUD_CYCLES = BAUD_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic supply_droop_reset,
   input wire logic sensor_stable,
   input wire logic mode_strap,
   input wire logic ambient_gate_in,
   input wire logic sleep_in_n,
   input wire logic motion_event,
   input wire logic [3:0] hold_time_setting,
   input wire logic [7:0] sensitivity_setting,
   input wire logic rxd,
   output logic txd,
   output logic motion_out_n,
   output logic serial_mode,
   output logic detect_enable,
   output logic [7:0] sensitivity_level
);

   if (STAB_CYCLES < 2 || TMO_CYCLES < 2 || SEC_CYCLES < 2 || SAMPLE_CYCLES < 2) begin : g_bad
      $error("pirm_ctrl: cycle counts must be at least 2");
   end

   // Five pin-level inputs through two flip-flops each
   logic [4:0] sync_m_q, sync_s_q;
   logic droop_s, stable_s, strap_s, light_s, sleep_n_s;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_m_q <= 5'h18;
         sync_s_q <= 5'h18;
      end else begin
         sync_m_q <= {sleep_in_n, ambient_gate_in, mode_strap, sensor_stable,
                      supply_droop_reset};
         sync_s_q <= sync_m_q;
      end
   end
   assign {sleep_n_s, light_s, strap_s, stable_s, droop_s} = sync_s_q;

   pirm_phase_e phase_q;
   pirm_cmd_e st_q, st_d;
   logic [31:0] stab_cnt_q, samp_cnt_q, sec_cnt_q, tmo_cnt_q;
   logic mode_q, run, reset_cmd_q, wake_q, sleep_act, det, start, out_act_q;
   logic light_eff, sleep_n_eff, tmo, rx_valid, tx_ready, tx_pend_q, rd_status;
   logic reply_v, wr_en, exec_reset, unsol_q;
   logic [9:0] hold_s, left_q;
   logic [7:0] rx_data, tx_byte_q, reply_b, stat_q, act_q, sens_q, wcmd_q, wcmd_d;
   logic [1:0] idx_q, idx_d, settle_q;
   pirm_pins_s pins_q;

   // Hold lasts until the synchronisers carry real pin levels, else the strap reads low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         settle_q <= 2'd0;
      end else if (settle_q != SYNC_CYC) begin
         settle_q <= settle_q + 2'd1;
      end
   end

   // Droop holds the sequence in reset; a confirmed reset restarts it too
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_q <= PH_HOLD;
      end else if (droop_s || reset_cmd_q) begin
         phase_q <= PH_HOLD;
      end else begin
         case (phase_q)
            PH_HOLD: phase_q <= (settle_q == SYNC_CYC) ? PH_STAB : PH_HOLD;
            PH_STAB: begin
               // Sensor reports stable, or the nominal wait runs out
               if (stable_s || stab_cnt_q == STAB_CYCLES - 1) begin
                  phase_q <= PH_RUN;
               end
            end
            PH_RUN: phase_q <= PH_RUN;
            default: phase_q <= PH_HOLD;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stab_cnt_q <= 32'h0;
      end else if (phase_q == PH_STAB) begin
         stab_cnt_q <= stab_cnt_q + 32'h1;
      end else begin
         stab_cnt_q <= 32'h0;
      end
   end

   // Strap is caught on every hold-state cycle without droop, so the value at leaving the hold state is kept
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mode_q <= 1'b0;
      end else if (phase_q == PH_HOLD && !droop_s) begin
         mode_q <= strap_s;
      end
   end

   assign run = (phase_q == PH_RUN);
   assign serial_mode = mode_q;

   // Pin mode refreshes its settings on a slow tick
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         samp_cnt_q <= 32'h0;
         pins_q <= '{hold: 4'h0, sens: 8'h00, light: 1'b1, sleep_n: 1'b1};
      end else begin
         samp_cnt_q <= (samp_cnt_q == SAMPLE_CYCLES - 1) ? 32'h0 : samp_cnt_q + 32'h1;
         if (phase_q == PH_HOLD || (!mode_q && samp_cnt_q == 32'h0)) begin
            pins_q <= '{hold: hold_time_setting, sens: sensitivity_setting,
                        light: light_s, sleep_n: sleep_n_s};
         end
      end
   end

   assign light_eff = mode_q ? light_s : pins_q.light;
   assign sleep_n_eff = mode_q ? sleep_n_s : pins_q.sleep_n;
   assign sensitivity_level = mode_q ? sens_q : pins_q.sens;
   assign hold_s = mode_q ? {2'b00, act_q} : hold_secs(pins_q.hold);

   // Serial mode: a received character overrides a low sleep input
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else if (sleep_n_eff || droop_s) begin
         wake_q <= 1'b0;
      end else if (mode_q && rx_valid) begin
         wake_q <= 1'b1;
      end
   end

   assign sleep_act = !sleep_n_eff && !wake_q;
   assign detect_enable = run && !sleep_act;
   assign det = detect_enable && motion_event;
   assign start = det && !light_eff && hold_s != 10'h000;

   // Hold timer in whole seconds; a retrigger restarts the full hold.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_act_q <= 1'b0;
         left_q <= 10'h000;
         sec_cnt_q <= 32'h0;
      end else if (!run || sleep_act || droop_s || reset_cmd_q) begin
         out_act_q <= 1'b0;
         left_q <= 10'h000;
         sec_cnt_q <= 32'h0;
      end else if (start) begin
         out_act_q <= 1'b1;
         left_q <= hold_s;
         sec_cnt_q <= 32'h0;
      end else if (out_act_q) begin
         // Light arriving mid-hold does not cut the hold short.
         if (sec_cnt_q == SEC_CYCLES - 1) begin
            sec_cnt_q <= 32'h0;
            left_q <= left_q - 10'h001;
            out_act_q <= (left_q > 10'h001);
         end else begin
            sec_cnt_q <= sec_cnt_q + 32'h1;
         end
      end
   end
   assign motion_out_n = !out_act_q;

   // Set wins over the clear by a status read
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stat_q <= CH_UNSTABLE;
      end else if (!run) begin
         stat_q <= CH_UNSTABLE;
      end else if (det) begin
         stat_q <= CH_YES;
      end else if (rd_status || stat_q == CH_UNSTABLE) begin
         stat_q <= CH_NO;
      end
   end

   // Idle-gap timer for write data and confirmation bytes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tmo_cnt_q <= 32'h0;
      end else if (st_q == CI_IDLE || rx_valid) begin
         tmo_cnt_q <= 32'h0;
      end else if (!tmo) begin
         tmo_cnt_q <= tmo_cnt_q + 32'h1;
      end
   end
   assign tmo = (tmo_cnt_q == TMO_CYCLES - 1);

   // Commands are ASCII letters; write data is taken as a raw byte
   always_comb begin
      st_d = st_q;
      idx_d = idx_q;
      wcmd_d = wcmd_q;
      reply_v = 1'b0;
      reply_b = CH_NACK;
      wr_en = 1'b0;
      rd_status = 1'b0;
      exec_reset = 1'b0;
      case (st_q)
         CI_IDLE: begin
            if (rx_valid && mode_q && phase_q != PH_HOLD) begin
               reply_v = 1'b1;
               case (rx_data)
                  CMD_STATUS_RD: begin
                     reply_b = stat_q;
                     rd_status = 1'b1;
                  end
                  CMD_ACT_RD: reply_b = act_q;
                  CMD_UNSOL_RD: reply_b = unsol_q ? CH_YES : CH_NO;
                  CMD_SENS_RD: reply_b = sens_q;
                  CMD_ACT_WR, CMD_UNSOL_WR, CMD_SENS_WR: begin
                     // Current value first, then wait for the new byte
                     reply_b = (rx_data == CMD_ACT_WR) ? act_q :
                               (rx_data == CMD_SENS_WR) ? sens_q :
                               (unsol_q ? CH_YES : CH_NO);
                     wcmd_d = rx_data;
                     st_d = CI_WDATA;
                  end
                  CMD_RESET: begin
                     reply_b = CH_ACK;
                     idx_d = 2'd0;
                     st_d = CI_CONF;
                  end
                  default: reply_b = CH_NACK;
               endcase
            end
         end
         CI_WDATA: begin
            if (rx_valid) begin
               reply_v = 1'b1;
               reply_b = CH_ACK;
               wr_en = 1'b1;
               st_d = CI_IDLE;
            end else if (tmo) begin
               reply_v = 1'b1;
               reply_b = CH_NACK;
               st_d = CI_IDLE;
            end
         end
         CI_CONF: begin
            if (rx_valid) begin
               if (rx_data != conf_byte(idx_q)) begin
                  reply_v = 1'b1;
                  reply_b = CH_NACK;
                  st_d = CI_IDLE;
               end else if (idx_q == 2'd3) begin
                  reply_v = 1'b1;
                  reply_b = CH_ACK;
                  exec_reset = 1'b1;
                  st_d = CI_IDLE;
               end else begin
                  idx_d = idx_q + 2'd1;
               end
            end else if (tmo) begin
               reply_v = 1'b1;
               reply_b = CH_NACK;
               st_d = CI_IDLE;
            end
         end
         default: st_d = CI_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_q <= CI_IDLE;
         idx_q <= 2'd0;
         wcmd_q <= 8'h00;
         reset_cmd_q <= 1'b0;
      end else if (droop_s) begin
         st_q <= CI_IDLE;
         idx_q <= 2'd0;
         reset_cmd_q <= 1'b0;
      end else begin
         st_q <= st_d;
         idx_q <= idx_d;
         wcmd_q <= wcmd_d;
         reset_cmd_q <= exec_reset;
      end
   end

   // Programmed settings; a droop brings them back to their defaults
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         act_q <= ACT_RST;
         sens_q <= SENS_RST;
         unsol_q <= 1'b0;
      end else if (droop_s) begin
         act_q <= ACT_RST;
         sens_q <= SENS_RST;
         unsol_q <= 1'b0;
      end else if (wr_en) begin
         case (wcmd_q)
            CMD_ACT_WR: act_q <= rx_data;
            CMD_SENS_WR: sens_q <= rx_data;
            CMD_UNSOL_WR: unsol_q <= (rx_data == CH_YES);
            default: act_q <= act_q;
         endcase
      end
   end

   // One-byte reply slot; a reply wins over an unsolicited report, which is
   // dropped while the slot is busy rather than queued
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_pend_q <= 1'b0;
         tx_byte_q <= 8'h00;
      end else if (droop_s) begin
         tx_pend_q <= 1'b0;
      end else if (reply_v) begin
         tx_pend_q <= 1'b1;
         tx_byte_q <= reply_b;
      end else if (mode_q && unsol_q && det && !tx_pend_q) begin
         tx_pend_q <= 1'b1;
         tx_byte_q <= CH_YES;
      end else if (tx_ready) begin
         tx_pend_q <= 1'b0;
      end
   end

   pirm_uart #(.DIV(BAUD_CYCLES)) u_uart (
      .clock(clock),
      .rst(rst),
      .rxd(rxd),
      .rx_valid(rx_valid),
      .rx_data(rx_data),
      .tx_valid(tx_pend_q),
      .tx_ready(tx_ready),
      .tx_data(tx_byte_q),
      .txd(txd)
   );

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_conf_last;
      st_q == CI_CONF && idx_q == 2'd3 && rx_valid && rx_data == conf_byte(2'd3);
   endsequence

   chk_stab_quiet: assert property (phase_q != PH_RUN |-> motion_out_n)
      else $error("motion output active before stable");
   chk_stab_wait: assert property ($rose(run) |-> $past(stable_s) ||
      $past(stab_cnt_q) == STAB_CYCLES - 1)
      else $error("run entered before stabilisation");
   chk_droop_hold: assert property (droop_s |=> phase_q == PH_HOLD ##1 !run)
      else $error("droop did not hold reset");
   chk_strap_once: assert property (phase_q != PH_HOLD |=> $stable(mode_q))
      else $error("mode changed outside hold");
   chk_gate_start: assert property ($fell(motion_out_n) |-> $past(det && !light_eff))
      else $error("output activated without motion or under light");
   chk_hold_load: assert property (start |=> left_q == $past(hold_s) && !motion_out_n)
      else $error("hold time not loaded");
   chk_sleep_quiet: assert property (sleep_act |=> motion_out_n)
      else $error("output active in sleep");
   chk_wake_char: assert property (mode_q && sleep_act && rx_valid && !droop_s
      |=> !sleep_act)
      else $error("character did not wake");
   chk_read_reply: assert property (st_q == CI_IDLE && rx_valid && mode_q && run &&
      rx_data == CMD_ACT_RD |=> tx_pend_q && tx_byte_q == $past(act_q))
      else $error("read reply wrong");
   chk_write_ack: assert property (st_q == CI_WDATA && rx_valid && !droop_s
      |=> tx_byte_q == CH_ACK && st_q == CI_IDLE)
      else $error("write data not acknowledged");
   chk_wr_timeout: assert property (st_q == CI_WDATA && tmo && !rx_valid && !droop_s
      |=> tx_pend_q && tx_byte_q == CH_NACK && st_q == CI_IDLE)
      else $error("write time-out without NACK");
   chk_conf_exec: assert property (s_conf_last ##0 !droop_s |=> reset_cmd_q &&
      tx_byte_q == CH_ACK ##1 phase_q == PH_HOLD)
      else $error("confirmed command not executed");
   chk_conf_bad: assert property (st_q == CI_CONF && rx_valid && !droop_s &&
      rx_data != conf_byte(idx_q) |=> tx_byte_q == CH_NACK && !reset_cmd_q)
      else $error("bad sequence not refused");
   chk_unknown_nack: assert property (st_q == CI_IDLE && rx_valid && mode_q && run &&
      !droop_s && rx_data inside {8'h23, 8'h41, 8'h51} |=> tx_byte_q == CH_NACK)
      else $error("unknown command not refused");
   chk_status_set: assert property (det && !droop_s |=> stat_q == CH_YES)
      else $error("motion status not latched");
   chk_tx_cause: assert property ($rose(tx_pend_q) |-> $past(reply_v) ||
      $past(unsol_q && det))
      else $error("unprompted transmission");

endmodule

// *** pirm_host.sv ***
// Host model for the serial link: sends bytes, collects replies.
// Assumes BAUD clocks a bit; drives and samples on falling edges.
`timescale 1ns/10ps
module pirm_host #(parameter int BAUD = 8) (
   input wire logic clock,
   input wire logic txd,
   output logic rxd
);
   initial rxd = 1'b1;
   // Start low, LSB first, one stop, idle high
   task automatic put(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd = f[i];
         repeat (BAUD) @(negedge clock);
      end
   endtask
   // Gives up after lim clocks, leaving an unknown that never matches
   task automatic get(input int lim, output logic [7:0] b);
      int n;
      n = 0;
      b = 8'hxx;
      while (txd !== 1'b0 && n < lim) begin
         @(negedge clock);
         n++;
      end
      if (n < lim) begin
         repeat (BAUD / 2) @(negedge clock);
         for (int i = 0; i < 8; i++) begin
            repeat (BAUD) @(negedge clock);
            b[i] = txd;
         end
         repeat (BAUD) @(negedge clock);
      end
   endtask
endmodule

// *** test_pirm_ctrl.sv ***
// Bench for the motion module controller, host model on the link.
// Assumes short counts: 400 to settle, 2000 time-out, 20 clocks a second.
`timescale 1ns/10ps
module test_pirm_ctrl;
   import pirm_pkg::*;
   typedef struct packed {logic [7:0] cmd; logic [7:0] rep;} pirm_row_s;
   logic clock, rst, supply_droop_reset, sensor_stable, mode_strap;
   logic ambient_gate_in, sleep_in_n, motion_event, rxd, txd;
   logic motion_out_n, serial_mode, detect_enable;
   logic [3:0] hold_time_setting;
   logic [7:0] sensitivity_setting;
   logic [7:0] sensitivity_level, r;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   pirm_row_s rows[6] = '{'{8'h64, 8'h02}, '{8'h73, 8'h10}, '{8'h6d, 8'h4e},
      '{8'h61, 8'h4e}, '{8'h51, 8'h15}, '{8'h23, 8'h15}};
   pirm_ctrl #(.STAB_CYCLES(400), .TMO_CYCLES(2000), .SEC_CYCLES(20),
      .SAMPLE_CYCLES(10), .BAUD_CYCLES(8)) pirm_ctrl_i (.clock, .rst,
      .supply_droop_reset, .sensor_stable, .mode_strap, .ambient_gate_in,
      .sleep_in_n, .motion_event, .hold_time_setting, .sensitivity_setting,
      .rxd, .txd, .motion_out_n, .serial_mode, .detect_enable, .sensitivity_level);
   pirm_host #(.BAUD(8)) pirm_host_i (.clock, .txd, .rxd);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // A hang ends the run as a mismatch
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic cb(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask
   task automatic xact(input logic [7:0] c, input logic [7:0] e);
      logic [7:0] q;
      fork
         pirm_host_i.put(c);
         pirm_host_i.get(200, q);
      join
      chk(q, e);
   endtask
   task automatic pulse();
      motion_event = 1'b1;
      @(negedge clock);
      motion_event = 1'b0;
   endtask
   initial begin
      {rst, supply_droop_reset, sensor_stable, mode_strap} = 4'b1001;
      {ambient_gate_in, sleep_in_n, motion_event} = 3'b010;
      {hold_time_setting, sensitivity_setting} = {4'h0, 8'h5a};
      repeat (12) @(negedge clock);
      cb(motion_out_n, 1'b1);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      cb(serial_mode, 1'b1);
      pulse();
      xact(CMD_STATUS_RD, CH_UNSTABLE);
      cb(motion_out_n, 1'b1);
      repeat (400) @(negedge clock);
      foreach (rows[i]) xact(rows[i].cmd, rows[i].rep);
      xact(CMD_ACT_WR, ACT_RST);
      xact(8'h03, CH_ACK);
      xact(CMD_ACT_RD, 8'h03);
      ambient_gate_in = 1'b1;
      repeat (4) @(negedge clock);
      pulse();
      repeat (3) @(negedge clock);
      cb(motion_out_n, 1'b1);
      ambient_gate_in = 1'b0;
      xact(CMD_UNSOL_WR, CH_NO);
      xact(CH_YES, CH_ACK);
      fork
         pirm_host_i.get(50, r);
         begin
            pulse();
            repeat (50) @(negedge clock);
            cb(motion_out_n, 1'b0);
            repeat (15) @(negedge clock);
            cb(motion_out_n, 1'b1);
         end
      join
      chk(r, CH_YES);
      xact(CMD_STATUS_RD, CH_YES);
      xact(CMD_STATUS_RD, CH_NO);
      sleep_in_n = 1'b0;
      repeat (4) @(negedge clock);
      cb(detect_enable, 1'b0);
      pulse();
      repeat (2) @(negedge clock);
      cb(motion_out_n, 1'b1);
      xact(CMD_ACT_RD, 8'h03);
      cb(detect_enable, 1'b1);
      sleep_in_n = 1'b1;
      xact(CMD_SENS_WR, SENS_RST);
      pirm_host_i.get(2500, r);
      chk(r, CH_NACK);
      xact(CMD_RESET, CH_ACK);
      pirm_host_i.put(8'h31);
      xact(8'h39, CH_NACK);
      xact(CMD_RESET, CH_ACK);
      for (int i = 0; i < 3; i++) pirm_host_i.put(8'(8'h31 + i));
      xact(8'h34, CH_ACK);
      repeat (2) @(negedge clock);
      cb(detect_enable, 1'b0);
      {supply_droop_reset, mode_strap, sensor_stable} = 3'b101;
      repeat (6) @(negedge clock);
      supply_droop_reset = 1'b0;
      repeat (30) @(negedge clock);
      cb(serial_mode, 1'b0);
      chk(sensitivity_level, 8'h5a);
      cb(detect_enable, 1'b1);
      pulse();
      repeat (30) @(negedge clock);
      cb(motion_out_n, 1'b0);
      repeat (15) @(negedge clock);
      cb(motion_out_n, 1'b1);
      {hold_time_setting, sensitivity_setting} = {4'h1, 8'h3c};
      repeat (15) @(negedge clock);
      chk(sensitivity_level, 8'h3c);
      pulse();
      repeat (90) @(negedge clock);
      cb(motion_out_n, 1'b0);
      repeat (15) @(negedge clock);
      cb(motion_out_n, 1'b1);
      stop_test();
   end
endmodule
